// File: host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
   import pwrseq_pkg::*;
(
   input wire logic i_clk_sys, // clock
   input wire logic i_wait, // waitrequest
   input wire logic [31:0] i_rdata, // read data
   output var pwrseq_pkg::av_req_t o_av // request
);
   initial o_av = '0;
   // hold keeps a burst beat up so the next beat follows without a gap
   task automatic xfer(input logic wr, bu, hold, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output bit ok);
      ok = 0;
      o_av <= '{address: a, read: !wr, write: wr, writedata: d, burst: bu};
      for (int n = 0; n < 20 && !ok; n++) begin
         @(posedge i_clk_sys);
         if (i_wait === 1'b0) begin
            ok = 1;
            q = i_rdata;
         end
      end
      if (!hold) begin
         o_av <= '0;
         @(posedge i_clk_sys);
      end
   endtask
endmodule // host_model
`default_nettype wire

// File: pwr_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pwr_timer #(
   parameter int WIDTH = 16
) (
   input wire logic i_clk_sys, // system clock
   input wire logic i_resetn, // sync reset, active low
   input wire logic i_start, // load and run
   input wire logic [WIDTH-1:0] i_count, // cycles to wait
   output logic o_done // level, high once count ran out
);
   logic [WIDTH-1:0] cnt_ff, nxt_cnt;
   logic done_ff, nxt_done;
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_done = done_ff;
      if (i_start) begin
         nxt_cnt = i_count;
         nxt_done = 1'b0;
      end else if (!done_ff) begin
         if (cnt_ff <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
            nxt_done = 1'b1;
         end else begin
            nxt_cnt = cnt_ff - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         cnt_ff <= '0;
         done_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         done_ff <= nxt_done;
      end
   end
   assign o_done = done_ff;
endmodule // pwr_timer
`default_nettype wire

// File: pwrseq_pkg.sv
`default_nettype none
package pwrseq_pkg;
   // register offsets (byte addresses, one word each)
   localparam logic [7:0] ADDR_IFCFG = 8'h00;
   localparam logic [7:0] ADDR_STREAM = 8'h04;
   localparam logic [7:0] ADDR_CALTRIG = 8'h40;
   localparam logic [7:0] ADDR_PD0 = 8'h64;
   localparam logic [7:0] ADDR_PD1 = 8'h68;
   localparam logic [7:0] ADDR_FREQ = 8'h80;
   localparam logic [7:0] ADDR_STATUS = 8'h84;
   // interface config fields and the stream-disable field
   localparam int IF_FOUR_WIRE = 0;
   localparam int IF_IO_LEVEL = 1;
   localparam int IF_ADDR_INC = 2;
   localparam int IF_DB_DIS = 3;
   localparam int STREAM_DIS = 0;
   // power-down fields
   localparam int PD0_GROUP = 0;
   localparam int PD1_GLOBAL = 0;
   localparam int PD1_REFDET = 1;
   localparam int PD1_OUT1 = 2;
   localparam int PD1_OUT2 = 3;
   // reset values
   localparam logic [31:0] RST_IFCFG = 32'h0000_0000;
   localparam logic [31:0] RST_STREAM = 32'h0000_0000;
   localparam logic [31:0] RST_PD0 = 32'h0000_0000;
   localparam logic [31:0] RST_PD1 = 32'h0000_000F;
   localparam logic [31:0] RST_FREQ = 32'h0000_0000;
   // timing
   localparam int CLK_HZ = 40_000_000;
   localparam int CE_SETTLE_US = 200;
   localparam int PD_SETTLE_US = 10;
   localparam int CE_SETTLE_CYC = (CE_SETTLE_US * (CLK_HZ / 1000) + 999) / 1000;
   localparam int PD_SETTLE_CYC = (PD_SETTLE_US * (CLK_HZ / 1000) + 999) / 1000;

   typedef enum {ST_OFF, ST_SETTLE, ST_PROG, ST_WAKE, ST_READY, ST_RUN}
      seq_state_t;

   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic burst;
   } av_req_t;
endpackage
`default_nettype wire

// File: synth_powerup_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: writing the calibration trigger starts calibration and loads buffered fields.
// R2: host writes the calibration trigger last in any sequence.
// R3: stream-disable set refuses burst transfers; clear accepts them.
// R4: host keeps all grouped internal power-down bits equal.
// R5: host sets grouped bits only for ambient temperature measurement.
// R6: global, ref-detector and both output power-downs act independently.
// R7: before chip enable the device is powered down and ignores writes.
// R8: host waits 200 us after chip enable before programming.
// R9: host first sets four-wire and io-level bits.
// R10: host programs registers from top address down to trigger.
// R11: device stays powered down until the global bit is cleared.
// R12: host waits 10 us after clearing global bit before triggering.
// R13: after calibration trigger, frequency may be reprogrammed any time.
// R14: global bit set powers down, keeps registers, port stays usable.
// R15: global bit cleared restores frequency, blocks powered within 10 us.
// R16: any chip-enable toggle powers down and resets all registers.
// R17: address-increment select picks burst direction up or down.
// R18: with double buffering off, writes go straight to active copy.
// R19: host measures waits with a cycle counter rounded up.
module synth_powerup_sequencer
   import pwrseq_pkg::*;
#(
   parameter int SETTLE_CYCLES = CE_SETTLE_CYC,
   parameter int WAKE_CYCLES = PD_SETTLE_CYC
) (
   input wire logic i_clk_sys, // 40 MHz clock
   input wire logic i_resetn, // sync reset, active low
   input wire logic i_chip_en, // chip-enable pin level
   input wire pwrseq_pkg::av_req_t i_av, // avalon request
   output logic [31:0] o_av_readdata, // avalon read data
   output logic o_av_waitrequest, // avalon wait
   output logic o_blocks_on, // internal blocks powered
   output logic o_cal_start, // one-cycle calibration pulse
   output logic [31:0] o_freq_active, // active frequency word
   output logic [3:0] o_pd_active // global,refdet,out1,out2 applied
);
   import pwrseq_pkg::*;

   seq_state_t st_ff, nxt_st;
   logic ce_q_ff, nxt_ce_q;
   logic [31:0] ifcfg_ff, nxt_ifcfg, stream_ff, nxt_stream;
   logic [31:0] pd0_ff, nxt_pd0, pd1_ff, nxt_pd1;
   logic [31:0] freq_main_ff, nxt_freq_main, freq_act_ff, nxt_freq_act;
   logic [31:0] rdata_ff, nxt_rdata;
   logic wait_ff, nxt_wait, cal_ff, nxt_cal, on_ff, nxt_on;
   logic [3:0] pda_ff, nxt_pda;
   logic [7:0] burst_addr_ff, nxt_burst_addr;
   logic in_burst_ff, nxt_in_burst;
   logic tmr_start;
   logic [15:0] tmr_count;
   logic tmr_done;
   logic acc, wr_ok, ce_edge;
   logic [7:0] eff_addr;

   pwr_timer #(.WIDTH(16)) u_timer (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_start(tmr_start),
      .i_count(tmr_count),
      .o_done(tmr_done)
   );

   assign ce_edge = i_chip_en != ce_q_ff;
   // one-cycle access: waitrequest drops the cycle after the request rises
   assign acc = (i_av.read || i_av.write) && wait_ff == 1'b0 ? 1'b0 :
                (i_av.read || i_av.write);

   always_comb begin
      nxt_st = st_ff;
      nxt_ce_q = i_chip_en;
      nxt_ifcfg = ifcfg_ff;
      nxt_stream = stream_ff;
      nxt_pd0 = pd0_ff;
      nxt_pd1 = pd1_ff;
      nxt_freq_main = freq_main_ff;
      nxt_freq_act = freq_act_ff;
      nxt_rdata = rdata_ff;
      nxt_wait = 1'b1;
      nxt_cal = 1'b0;
      nxt_burst_addr = burst_addr_ff;
      nxt_in_burst = in_burst_ff;
      tmr_start = 1'b0;
      tmr_count = 16'(SETTLE_CYCLES);
      eff_addr = in_burst_ff ? burst_addr_ff : i_av.address;
      wr_ok = 1'b0;
      // refused burst beats complete but change nothing
      if (acc && wait_ff) begin
         nxt_wait = 1'b0;
         wr_ok = i_av.write && st_ff != ST_OFF && st_ff != ST_SETTLE; // see R7
         if (i_av.burst && stream_ff[STREAM_DIS]) begin
            wr_ok = 1'b0; // see R3
         end
         nxt_rdata = 32'h0000_0000;
         case (eff_addr)
            ADDR_IFCFG: nxt_rdata = ifcfg_ff;
            ADDR_STREAM: nxt_rdata = stream_ff;
            ADDR_PD0: nxt_rdata = pd0_ff;
            ADDR_PD1: nxt_rdata = pd1_ff;
            ADDR_FREQ: nxt_rdata = ifcfg_ff[IF_DB_DIS] ? freq_act_ff
                                                        : freq_main_ff;
            ADDR_STATUS: nxt_rdata = {28'h0, tmr_done, on_ff, 2'(st_ff)};
            default: nxt_rdata = 32'h0000_0000;
         endcase
         if (wr_ok) begin
            case (eff_addr)
               ADDR_IFCFG: nxt_ifcfg = {28'h0, i_av.writedata[3:0]};
               ADDR_STREAM: nxt_stream = {31'h0, i_av.writedata[0]};
               ADDR_PD0: nxt_pd0 = {31'h0, i_av.writedata[PD0_GROUP]};
               ADDR_PD1: nxt_pd1 = {28'h0, i_av.writedata[3:0]}; // see R6
               ADDR_FREQ: begin
                  if (ifcfg_ff[IF_DB_DIS]) begin
                     nxt_freq_act = i_av.writedata; // see R18
                  end else begin
                     nxt_freq_main = i_av.writedata;
                  end
               end
               ADDR_CALTRIG: begin
                  nxt_cal = 1'b1; // see R1
                  nxt_freq_act = freq_main_ff; // see R1
               end
               default: ;
            endcase
         end
         // burst address steps after each accepted beat
         if (i_av.burst && !stream_ff[STREAM_DIS]) begin
            nxt_in_burst = 1'b1;
            nxt_burst_addr = ifcfg_ff[IF_ADDR_INC] ? eff_addr + 8'h04
                                                   : eff_addr - 8'h04; // see R17
         end else begin
            nxt_in_burst = 1'b0;
         end
      end
      case (st_ff)
         ST_OFF: if (i_chip_en) begin
            nxt_st = ST_SETTLE;
            tmr_start = 1'b1;
         end
         ST_SETTLE: if (tmr_done) nxt_st = ST_PROG;
         ST_PROG, ST_RUN: begin
            if (!nxt_pd1[PD1_GLOBAL]) begin // see R11
               nxt_st = ST_WAKE;
               tmr_start = 1'b1;
               tmr_count = 16'(WAKE_CYCLES);
            end
         end
         ST_WAKE: begin
            if (nxt_pd1[PD1_GLOBAL]) nxt_st = ST_PROG; // see R14
            else if (tmr_done) nxt_st = ST_READY; // see R15
         end
         ST_READY: begin
            if (nxt_pd1[PD1_GLOBAL]) nxt_st = ST_PROG; // see R14
            else if (nxt_cal) nxt_st = ST_RUN; // see R13
         end
         default: nxt_st = ST_OFF;
      endcase
      if (st_ff == ST_RUN && nxt_pd1[PD1_GLOBAL]) begin
         nxt_st = ST_PROG; // see R14
      end
      if (st_ff == ST_RUN && !nxt_pd1[PD1_GLOBAL]) begin
         nxt_st = ST_RUN; // see R13
      end
      nxt_on = nxt_st == ST_READY || nxt_st == ST_RUN;
      nxt_pda = {nxt_pd1[PD1_OUT2], nxt_pd1[PD1_OUT1], nxt_pd1[PD1_REFDET],
                 !nxt_on};
      if (ce_edge) begin
         nxt_st = ST_OFF; // see R16
         nxt_ifcfg = RST_IFCFG;
         nxt_stream = RST_STREAM;
         nxt_pd0 = RST_PD0;
         nxt_pd1 = RST_PD1;
         nxt_freq_main = RST_FREQ;
         nxt_freq_act = RST_FREQ;
         nxt_in_burst = 1'b0;
         nxt_on = 1'b0;
         nxt_cal = 1'b0;
         nxt_pda = 4'hF;
      end
      if (!(i_av.read || i_av.write)) nxt_in_burst = in_burst_ff && i_av.burst;
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         st_ff <= ST_OFF;
         ce_q_ff <= 1'b0;
         ifcfg_ff <= RST_IFCFG;
         stream_ff <= RST_STREAM;
         pd0_ff <= RST_PD0;
         pd1_ff <= RST_PD1;
         freq_main_ff <= RST_FREQ;
         freq_act_ff <= RST_FREQ;
         rdata_ff <= 32'h0000_0000;
         wait_ff <= 1'b1;
         cal_ff <= 1'b0;
         on_ff <= 1'b0;
         pda_ff <= 4'hF;
         burst_addr_ff <= 8'h00;
         in_burst_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         ce_q_ff <= nxt_ce_q;
         ifcfg_ff <= nxt_ifcfg;
         stream_ff <= nxt_stream;
         pd0_ff <= nxt_pd0;
         pd1_ff <= nxt_pd1;
         freq_main_ff <= nxt_freq_main;
         freq_act_ff <= nxt_freq_act;
         rdata_ff <= nxt_rdata;
         wait_ff <= nxt_wait;
         cal_ff <= nxt_cal;
         on_ff <= nxt_on;
         pda_ff <= nxt_pda;
         burst_addr_ff <= nxt_burst_addr;
         in_burst_ff <= nxt_in_burst;
      end
   end

   assign o_av_readdata = rdata_ff;
   assign o_av_waitrequest = wait_ff;
   assign o_blocks_on = on_ff;
   assign o_cal_start = cal_ff;
   assign o_freq_active = freq_act_ff;
   assign o_pd_active = pda_ff;
endmodule // synth_powerup_sequencer
`default_nettype wire

// File: synth_powerup_sequencer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pwrseq_checker
   import pwrseq_pkg::*;
#(
   parameter int WAKE_CYCLES = 10
) (
   input wire logic i_clk_sys, // clock
   input wire logic i_resetn, // reset, active low
   input wire logic i_chip_en, // chip enable
   input wire pwrseq_pkg::av_req_t i_av, // request
   input wire logic [31:0] o_av_readdata, // read data
   input wire logic o_av_waitrequest, // wait
   input wire logic o_blocks_on, // powered
   input wire logic o_cal_start, // cal pulse
   input wire logic [31:0] o_freq_active, // active word
   input wire logic [3:0] o_pd_active // applied pd
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   wire req = i_av.read | i_av.write;
   // cycles since the last accepted write to the power-down word
   int pd_gap_ff;
   always_ff @(posedge i_clk_sys) begin
      if (req && o_av_waitrequest && i_av.write &&
          i_av.address == ADDR_PD1) begin
         pd_gap_ff <= 0;
      end else if (pd_gap_ff < 1000) begin
         pd_gap_ff <= pd_gap_ff + 1;
      end
   end
   sequence off_s;
      !i_chip_en [*3];
   endsequence
   wait_one_a: assert property (!o_av_waitrequest |=> o_av_waitrequest)
      else $error("wait low too long");
   wait_answer_a: assert property (req && o_av_waitrequest |=> !o_av_waitrequest)
      else $error("no answer");
   cal_pulse_a: assert property (o_cal_start |=> !o_cal_start)
      else $error("cal pulse too long");
   cal_cause_a: assert property (o_cal_start |-> $past(i_av.write) &&
      $past(i_av.address) == ADDR_CALTRIG) else $error("stray cal");
   off_quiet_a: assert property (off_s |-> !o_blocks_on && !o_cal_start)
      else $error("active while disabled");
   ce_reset_a: assert property ($changed(i_chip_en) |-> ##[1:3]
      (o_pd_active == 4'hF && o_freq_active == 32'h0)) else $error("no reset");
   wake_min_a: assert property ($rose(o_blocks_on) |->
      pd_gap_ff >= WAKE_CYCLES) else $error("woke too soon");
   on_flag_a: assert property (o_pd_active[0] == !o_blocks_on)
      else $error("global flag wrong");
   rd_stand_a: assert property (!req [*2] |=> $stable(o_av_readdata))
      else $error("read data moved");
endmodule // pwrseq_checker
bind synth_powerup_sequencer pwrseq_checker #(.WAKE_CYCLES(WAKE_CYCLES)) chk (
   .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_chip_en(i_chip_en),
   .i_av(i_av), .o_av_readdata(o_av_readdata),
   .o_av_waitrequest(o_av_waitrequest), .o_blocks_on(o_blocks_on),
   .o_cal_start(o_cal_start), .o_freq_active(o_freq_active),
   .o_pd_active(o_pd_active));
`default_nettype wire

// File: synth_powerup_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module synth_powerup_sequencer_tb;
   import pwrseq_pkg::*;
   localparam int SET = 20;
   localparam int WAKE = 10;
   logic clk = 0, rstn = 0, ce = 0, wt, on, cal;
   av_req_t av;
   logic [31:0] rdata, freq;
   logic [3:0] pd;
   int bad_count = 0, checks_done = 0, cal_n = 0;
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) if (cal === 1'b1) cal_n++;
   synth_powerup_sequencer #(.SETTLE_CYCLES(SET), .WAKE_CYCLES(WAKE)) dut (
      .i_clk_sys(clk), .i_resetn(rstn), .i_chip_en(ce), .i_av(av),
      .o_av_readdata(rdata), .o_av_waitrequest(wt), .o_blocks_on(on),
      .o_cal_start(cal), .o_freq_active(freq), .o_pd_active(pd));
   host_model h (.i_clk_sys(clk), .i_wait(wt), .i_rdata(rdata), .o_av(av));
   task automatic summarize();
      $display("checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, e);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic acc(input logic w, b, o, input logic [7:0] a,
      input logic [31:0] d);
      logic [31:0] q;
      bit ok;
      h.xfer(w, b, o, a, d, q, ok);
      if (!ok) begin
         bad_count++;
         $display("unexpected at %0t: bus timeout", $time);
         summarize();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bit ok;
      h.xfer(0, 0, 0, a, 0, q, ok);
      chk({31'h0, ok}, 1);
      if (!ok) summarize();
      chk(q, e);
   endtask
   task automatic t_boot();
      int n;
      acc(1, 0, 0, ADDR_PD1, 32'h0);
      chk(on, 0);
      ce <= 1'b1;
      acc(1, 0, 0, ADDR_FREQ, 32'h1);
      repeat (SET + 4) @(posedge clk);
      rd(ADDR_FREQ, 32'h0);
      acc(1, 0, 0, ADDR_IFCFG, 32'h3);
      rd(ADDR_IFCFG, 32'h3);
      acc(1, 0, 0, ADDR_FREQ, 32'hA5);
      acc(1, 0, 0, ADDR_PD1, 32'h0);
      for (n = 0; on !== 1'b1 && n < 100; n++) @(posedge clk);
      if (on !== 1'b1) begin
         bad_count++;
         $display("unexpected at %0t: wake timeout", $time);
         summarize();
      end
      chk(n >= WAKE - 2 && n <= WAKE + 3, 1);
      chk(freq, 32'h0);
      n = cal_n;
      acc(1, 0, 0, ADDR_CALTRIG, 32'h1);
      repeat (2) @(posedge clk);
      chk(freq, 32'hA5);
      chk(cal_n, n + 1);
      $display("boot done");
   endtask
   task automatic t_pd();
      acc(1, 0, 0, ADDR_PD1, 32'h1);
      repeat (3) @(posedge clk);
      chk({on, pd[0]}, 2'b01);
      // grouped bits go high only in full power-down, all at once
      acc(1, 0, 0, ADDR_PD0, 32'h1);
      rd(ADDR_PD0, 32'h1);
      acc(1, 0, 0, ADDR_PD0, 32'h0);
      rd(ADDR_PD0, 32'h0);
      acc(1, 0, 0, ADDR_FREQ, 32'hB6);
      rd(ADDR_FREQ, 32'hB6);
      acc(1, 0, 0, ADDR_PD1, 32'hC);
      repeat (WAKE + 4) @(posedge clk);
      chk({on, pd}, 5'h1C);
      chk(freq, 32'hA5);
      $display("power-down done");
   endtask
   task automatic t_stream();
      acc(1, 0, 0, ADDR_IFCFG, 32'hB);
      acc(1, 0, 0, ADDR_FREQ, 32'h5A);
      repeat (2) @(posedge clk);
      chk(freq, 32'h5A);
      acc(1, 0, 0, ADDR_STREAM, 32'h1);
      acc(1, 1, 0, ADDR_FREQ, 32'h11);
      repeat (2) @(posedge clk);
      chk(freq, 32'h5A);
      acc(1, 0, 0, ADDR_STREAM, 32'h0);
      for (int u = 0; u < 2; u++) begin
         acc(1, 0, 0, ADDR_IFCFG, 32'hB | (u << 2));
         acc(1, 1, 1, u ? 8'h7C : ADDR_STATUS, 32'h0);
         acc(1, 1, 0, u ? 8'h7C : ADDR_STATUS, 32'h20 + u);
         repeat (2) @(posedge clk);
         chk(freq, 32'h20 + u);
      end
      $display("stream done");
   endtask
   task automatic t_ce();
      ce <= 1'b0;
      repeat (4) @(posedge clk);
      chk(on, 0);
      chk(freq, 32'h0);
      ce <= 1'b1;
      repeat (SET + 4) @(posedge clk);
      rd(ADDR_IFCFG, 32'h0);
      rd(ADDR_PD1, 32'hF);
      rd(ADDR_FREQ, 32'h0);
      rd(8'h10, 32'h0);
      $display("chip-enable done");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_boot();
      t_pd();
      t_stream();
      t_ce();
      summarize();
   end
endmodule // synth_powerup_sequencer_tb
`default_nettype wire
